//--- rtl/led_pulse_dimming_control.sv
// Purpose: enable, pulse-count dimming and low-time shutdown for four sinks
// Assumes: 100 MHz mclk; pin is asynchronous and synchronised here
// Notes: sink outputs are a current code plus an enable per channel
`timescale 1ns/1ps
`include "dim_ctrl_regs.svh"
module led_pulse_dimming_control
    import dim_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // One-wire input and supply monitor
    input wire logic enable_dimming_pin,
    input wire logic supply_low_lockout,
    // Sink controls
    output logic [14:0] sink_current_ua,
    output logic sink_output_one,
    output logic sink_output_two,
    output logic sink_output_three,
    output logic sink_output_four,
    // Status
    output logic [4:0] dim_level,
    output logic device_enabled
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed
    {
        mode_type mode_r;
        logic pin_d_r;
        logic [`LOW_CNT_W-1:0] low_cnt_r;
        logic short_low_r;
        logic [`LEVEL_W-1:0] level_r;
        logic [3:0] sink_en_r;
        logic enabled_r;
    } ctrl_state_type;

    ctrl_state_type cur_r;
    ctrl_state_type cur_nxt;
    logic pin_s;

    pin_sync i_pin_sync
    (
        .mclk(mclk),
        .srst(srst),
        .pin_in(enable_dimming_pin),
        .pin_out(pin_s)
    );

    level_scale i_level_scale
    (
        .mclk(mclk),
        .srst(srst),
        .level(cur_nxt.level_r),
        .on(cur_nxt.enabled_r),
        .current_ua(sink_current_ua)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.pin_d_r = pin_s;
        // Saturate so a long low never wraps the counter
        if (pin_s)
        begin
            cur_nxt.low_cnt_r = '0;
        end
        else if (cur_r.low_cnt_r != `LOW_CNT_W'(`SHUTDOWN_LOW_CYC))
        begin
            cur_nxt.low_cnt_r = cur_r.low_cnt_r + `LOW_CNT_W'(1);
        end
        // Remember whether the low phase just ended was too short
        if (!pin_s && cur_r.pin_d_r)
        begin
            cur_nxt.short_low_r = 1'b1;
        end
        else if (!pin_s && cur_r.low_cnt_r >= `LOW_CNT_W'(`PROGRAM_LOW_MIN_CYC - 1))
        begin
            cur_nxt.short_low_r = 1'b0;
        end
        unique case (cur_r.mode_r)
            ST_SHUTDOWN:
            begin
                if (pin_s && !supply_low_lockout)
                begin
                    cur_nxt.mode_r = ST_ENABLED;
                    cur_nxt.level_r = `LEVEL_FULL_SCALE;
                end
            end
            ST_ENABLED:
            begin
                if (!pin_s && cur_r.low_cnt_r == `LOW_CNT_W'(`SHUTDOWN_LOW_CYC - 1))
                begin
                    cur_nxt.mode_r = ST_SHUTDOWN;
                    cur_nxt.level_r = `LEVEL_FULL_SCALE;
                end
                else if (pin_s && !cur_r.pin_d_r && !cur_r.short_low_r)
                begin
                    // Five-bit wrap gives 31 -> zero, 32 -> full scale
                    cur_nxt.level_r = cur_r.level_r + `LEVEL_W'(1);
                end
            end
            // Two spare mode codes; fall back to the safe state
            default:
            begin
                cur_nxt.mode_r = ST_SHUTDOWN;
                cur_nxt.level_r = `LEVEL_FULL_SCALE;
            end
        endcase
        // Lockout overrides everything, pin included
        if (supply_low_lockout)
        begin
            cur_nxt.mode_r = ST_SHUTDOWN;
            cur_nxt.level_r = `LEVEL_FULL_SCALE;
        end
        cur_nxt.enabled_r = (cur_nxt.mode_r == ST_ENABLED);
        // Level 31 is zero current, so sinks release too
        cur_nxt.sink_en_r = {4{cur_nxt.enabled_r && cur_nxt.level_r != 5'h1f}};
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cur_r.mode_r <= ST_SHUTDOWN;
            cur_r.pin_d_r <= 1'b0;
            cur_r.low_cnt_r <= '0;
            cur_r.short_low_r <= 1'b0;
            cur_r.level_r <= `LEVEL_FULL_SCALE;
            cur_r.sink_en_r <= 4'h0;
            cur_r.enabled_r <= 1'b0;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign sink_output_one = cur_r.sink_en_r[0];
    assign sink_output_two = cur_r.sink_en_r[1];
    assign sink_output_three = cur_r.sink_en_r[2];
    assign sink_output_four = cur_r.sink_en_r[3];
    assign dim_level = cur_r.level_r;
    assign device_enabled = cur_r.enabled_r;

endmodule : led_pulse_dimming_control

//--- shared/dim_ctrl_regs.svh
// Purpose: timing counts and reset values for the one-wire dimming control
// Assumes: mclk at 100 MHz
// Notes: none
// Behaviour
// - First high level out of shutdown enables all sinks at full scale, 25 mA.
// - Input held low for about 3 ms puts the device in zero-current shutdown.
// - In shutdown every sink output is high-impedance and carries no current.
// - Supply-low lockout disables channels, enters shutdown, restores default level.
// - Exactly 32 current levels, chosen only by pulsing the input.
// - Each rising edge while enabled lowers current one step, 1/31 of full scale.
// - After n pulses current is 25 mA times (31 - n) / 31.
// - After 30 pulses the lowest non-zero level, about 3.2 percent, is reached.
// - Pulse 31 gives zero current; pulse 32 restores full scale, modulo 32.
// - Level follows pulses counted since enable; 16 pulses give 48 percent.
// - Low phases shorter than 200 ns may be filtered and not counted.
// - Low periods beyond the maximum program low time may mean shutdown.
// - Shutdown timeout lies between 2 ms and 5 ms, typically 3 ms.
`ifndef DIM_CTRL_REGS_SVH
`define DIM_CTRL_REGS_SVH

`define CLK_PERIOD_PS 10000
`define PROGRAM_LOW_MIN_NS 200
`define SHUTDOWN_LOW_TIME_US 3000
`define PROGRAM_LOW_MIN_CYC ((`PROGRAM_LOW_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SHUTDOWN_LOW_CYC ((`SHUTDOWN_LOW_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define LOW_CNT_W 19
`define LEVEL_W 5
`define LEVEL_FULL_SCALE 5'h00
`define LEVEL_STEPS 31
`define FULL_SCALE_UA 25000

`endif

//--- shared/dim_ctrl_pkg.sv
// Purpose: types for the one-wire dimming control
// Assumes: constants come from dim_ctrl_regs.svh
// Notes: none
package dim_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_ENABLED
    } mode_type;

endpackage : dim_ctrl_pkg

//--- rtl/pin_sync.sv
// Purpose: two-stage synchroniser for the enable/dimming pin
// Assumes: none
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Pin
    input wire logic pin_in,
    output logic pin_out
);

    typedef struct packed
    {
        logic meta_r;
        logic sync_r;
    } sync_state_type;

    sync_state_type cur_r;
    sync_state_type cur_nxt;

    always_comb
    begin
        cur_nxt.meta_r = pin_in;
        cur_nxt.sync_r = cur_r.meta_r;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cur_r <= '0;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    assign pin_out = cur_r.sync_r;

endmodule : pin_sync

//--- rtl/level_scale.sv
// Purpose: turns a pulse count into a sink current in microamps
// Assumes: count 0 is full scale
// Notes: registered output
`timescale 1ns/1ps
`include "dim_ctrl_regs.svh"
module level_scale
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Level
    input wire logic [4:0] level,
    input wire logic on,
    output logic [14:0] current_ua
);

    typedef struct packed
    {
        logic [14:0] cur_ua_r;
    } scale_state_type;

    scale_state_type cur_r;
    scale_state_type cur_nxt;

    // Current for a count n: 25 mA * (31 - n) / 31
    function automatic logic [14:0] level_to_ua(input logic [4:0] n);
        logic [19:0] prod;
        prod = 20'(`FULL_SCALE_UA) * 20'(5'(`LEVEL_STEPS) - n);
        return 15'(prod / 20'(`LEVEL_STEPS));
    endfunction : level_to_ua

    always_comb
    begin
        cur_nxt.cur_ua_r = on ? level_to_ua(level) : 15'h0000;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cur_r <= '0;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    assign current_ua = cur_r.cur_ua_r;

endmodule : level_scale

//--- verif/host_pulser.sv
// Purpose: host model that pulses the one-wire pin
// Assumes: pin has a pull-down, so idle is low
// Notes: callers enter the tasks at a rising edge
`timescale 1ns/1ps
module host_pulser
(
    // Clock
    input wire logic mclk,
    // Pin
    output logic pin
);
    initial pin = 1'b0;
    task automatic hold(input logic v, input int n);
        pin <= v;
        repeat (n) @(posedge mclk);
    endtask : hold
    // High phase kept long so every low is judged alone
    task automatic pulse(input int lo);
        hold(1'b0, lo);
        hold(1'b1, 25);
    endtask : pulse
endmodule : host_pulser

//--- verif/dim_ctrl_asserts.sv
// Purpose: port checks of the dimming control
// Assumes: ports of led_pulse_dimming_control
// Notes: timeout shutdown left out, 3 ms is too long a run
`timescale 1ns/1ps
module dim_ctrl_asserts
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Inputs
    input wire logic enable_dimming_pin,
    input wire logic supply_low_lockout,
    // Outputs
    input wire logic [14:0] sink_current_ua,
    input wire logic sink_output_one,
    input wire logic sink_output_two,
    input wire logic sink_output_three,
    input wire logic sink_output_four,
    input wire logic [4:0] dim_level,
    input wire logic device_enabled
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [18:0] low_r;
    logic [14:0] exp_ua;
    // Scaler registers the next state, so current tracks level in the same cycle
    assign exp_ua = device_enabled ? 15'(25000 * (31 - dim_level) / 31) : 15'h0;
    ////////////////////////////////////////////////////////////////
    // Raw low length, saturating
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            low_r <= 19'h0;
        end
        else
        begin
            low_r <= enable_dimming_pin ? 19'h0 : low_r + {18'h0, ~&low_r};
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence s_held;
        (enable_dimming_pin && !supply_low_lockout)[*4];
    endsequence
    sequence s_wake;
        !device_enabled && $rose(enable_dimming_pin) ##0 s_held;
    endsequence
    sequence s_good_rise;
        device_enabled && $rose(enable_dimming_pin) && low_r > 19'd22 && low_r < 19'd200000 ##1 s_held;
    endsequence
    sequence s_short_rise;
        device_enabled && $rose(enable_dimming_pin) && low_r < 19'd15 ##1 s_held;
    endsequence
    property p_wake;
        s_wake |-> ##[0:2] (device_enabled && dim_level == 5'h00);
    endproperty
    a_wake: assert property (p_wake) else $error("no full scale enable");
    property p_count;
        s_good_rise |-> dim_level == $past(dim_level, 4) + 5'h01;
    endproperty
    a_count: assert property (p_count) else $error("pulse not counted");
    property p_short;
        s_short_rise |-> dim_level == $past(dim_level, 4);
    endproperty
    a_short: assert property (p_short) else $error("short low counted");
    property p_step;
        $past(device_enabled) && device_enabled && dim_level != $past(dim_level)
            |-> dim_level == $past(dim_level) + 5'h01;
    endproperty
    a_step: assert property (p_step) else $error("level moved by other than one");
    property p_lock;
        supply_low_lockout |=> !device_enabled && dim_level == 5'h00;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout ignored");
    property p_sinks;
        {sink_output_one, sink_output_two, sink_output_three, sink_output_four}
            == {4{device_enabled && dim_level != 5'h1f}};
    endproperty
    a_sinks: assert property (p_sinks) else $error("sink enables wrong");
    property p_current;
        sink_current_ua == exp_ua;
    endproperty
    a_current: assert property (p_current) else $error("sink current wrong");
    property p_keep;
        device_enabled && !supply_low_lockout && low_r < 19'd200000 |=> device_enabled;
    endproperty
    a_keep: assert property (p_keep) else $error("early shutdown");
endmodule : dim_ctrl_asserts

//--- verif/led_pulse_dimming_control_bench.sv
// Purpose: self-checking bench of the dimming control
// Assumes: 100 MHz mclk
// Notes: shutdown by timeout left to lockout path, run length
`timescale 1ns/1ps
module led_pulse_dimming_control_bench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic supply_low_lockout = 1'b0;
    logic pin;
    logic [14:0] sink_current_ua;
    logic [3:0] sinks;
    logic [4:0] dim_level;
    logic device_enabled;
    int n_fail = 0;
    int checks = 0;
    initial forever #5 mclk = ~mclk;
    host_pulser i_host_pulser (.mclk(mclk), .pin(pin));
    led_pulse_dimming_control i_led_pulse_dimming_control (.mclk, .srst, .enable_dimming_pin(pin),
        .supply_low_lockout, .sink_current_ua, .sink_output_one(sinks[3]), .sink_output_two(sinks[2]),
        .sink_output_three(sinks[1]), .sink_output_four(sinks[0]), .dim_level, .device_enabled);
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [14:0] got, input logic [14:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk
    // Expected state after n counted pulses
    task automatic see(input int n, input logic on);
        int m;
        m = n % 32;
        chk("enabled", device_enabled, on);
        chk("level", dim_level, on ? 5'(m) : 5'h00);
        chk("current", sink_current_ua, on ? 15'(25000 * (31 - m) / 31) : 15'h0);
        chk("sinks", sinks, (on && m != 31) ? 4'hf : 4'h0);
    endtask : see
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        see(0, 1'b0);
        i_host_pulser.hold(1'b1, 30);
        see(0, 1'b1);
        $display("enable done");
        for (int n = 1; n <= 32; n++)
        begin
            i_host_pulser.pulse(25);
            see(n, 1'b1);
        end
        $display("dimming done");
        i_host_pulser.pulse(5);
        see(0, 1'b1);
        $display("short low done");
        i_host_pulser.pulse(10000);
        see(1, 1'b1);
        $display("long low done");
        supply_low_lockout <= 1'b1;
        i_host_pulser.hold(1'b0, 30);
        see(0, 1'b0);
        supply_low_lockout <= 1'b0;
        i_host_pulser.hold(1'b1, 30);
        see(0, 1'b1);
        $display("lockout done");
        end_sim();
    end
    // Hang guard
    initial
    begin
        repeat (50000) @(posedge mclk);
        n_fail++;
        end_sim();
    end
endmodule : led_pulse_dimming_control_bench
bind led_pulse_dimming_control dim_ctrl_asserts i_dim_ctrl_asserts (.mclk, .srst, .enable_dimming_pin,
    .supply_low_lockout, .sink_current_ua, .sink_output_one, .sink_output_two, .sink_output_three,
    .sink_output_four, .dim_level, .device_enabled);
